// >>> inc/pmq_params.svh
// constants for the event qualifier and fixed counter block
`ifndef PMQ_PARAMS_SVH
`define PMQ_PARAMS_SVH

// register addresses on the msr port
`define PMQ_ADDR_SEL0    8'h00
`define PMQ_ADDR_SEL1    8'h01
`define PMQ_ADDR_GPC0    8'h02
`define PMQ_ADDR_GPC1    8'h03
`define PMQ_ADDR_FIX0    8'h04
`define PMQ_ADDR_FIX1    8'h05
`define PMQ_ADDR_FIX2    8'h06
`define PMQ_ADDR_FIXCTL  8'h07
`define PMQ_ADDR_GLOB    8'h08

// event selector fields
`define PMQ_SEL_UM_LSB   8
`define PMQ_SEL_UM_MSB   15
`define PMQ_SEL_USR      16
`define PMQ_SEL_OS       17
`define PMQ_SEL_EN       22
`define PMQ_SEL_WMASK    32'h0043ffff
`define PMQ_SEL_RST      32'h00000000

// unit mask sub-fields, positions inside the 8-bit mask
`define PMQ_UM_CORE_HI   7
`define PMQ_UM_CORE_LO   6
`define PMQ_UM_AGENT     5
`define PMQ_UM_PF_HI     5
`define PMQ_UM_PF_LO     4
`define PMQ_CORE_ALL     2'b11
`define PMQ_CORE_SELF    2'b01
`define PMQ_PF_ALL       2'b11
`define PMQ_PF_ONLY      2'b01
`define PMQ_PF_EXCL      2'b00
`define PMQ_UM_HIT_MODIFIED_RESPONSE      3
`define PMQ_UM_HIT       1
`define PMQ_UM_CLEAN     0
`define PMQ_UM_SNP_INV   1
`define PMQ_UM_SNP_SHR   0

// fixed counter control fields
`define PMQ_FC_W         4
`define PMQ_FC_OS        0
`define PMQ_FC_USR       1
`define PMQ_FC_PMI       3
`define PMQ_FIXCTL_WMASK 12'hbbb
`define PMQ_FIXCTL_RST   12'h000

// global enable layout
`define PMQ_GLOB_GP_LSB  0
`define PMQ_GLOB_FX_LSB  32
`define PMQ_GLOB_RST     5'h00

`endif

// >>> inc/pmq_pkg.sv
// types shared by the event qualifier and fixed counter block
package pmq_pkg;

   // second topology qualifier: agent and prefetch exclude each other
   typedef enum logic [2:0]
   {
      PMQ_SIDE_NONE  = 3'b001,
      PMQ_SIDE_AGENT = 3'b010,
      PMQ_SIDE_PF    = 3'b100
   } pmq_side_t;

   // at most one of the low-nibble qualifiers per event
   typedef enum logic [3:0]
   {
      PMQ_ST_NONE   = 4'b0001,
      PMQ_ST_MESI   = 4'b0010,
      PMQ_ST_SNRESP = 4'b0100,
      PMQ_ST_SNTYPE = 4'b1000
   } pmq_state_t;

   typedef struct packed
   {
      logic       core_spec;
      pmq_side_t  side;
      pmq_state_t state;
   } pmq_caps_t;

   typedef struct packed
   {
      logic       valid;
      logic       self_core;
      logic       self_agent;
      logic       hw_pf;
      logic [3:0] mesi;
      logic [2:0] snp_resp;
      logic [1:0] snp_type;
   } pmq_event_t;

   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [63:0] wdata;
   } pmq_msr_req_t;

   typedef struct packed
   {
      logic        valid;
      logic        fault;
      logic [63:0] rdata;
   } pmq_msr_rsp_t;

endpackage

// >>> src/pmq_umask_qual.sv
// unit mask qualifier for one general-purpose event stream
`timescale 1ns/1ps
`default_nettype none
`include "pmq_params.svh"

module pmq_umask_qual
(
   input  wire logic [7:0]         umask,
   input  wire pmq_pkg::pmq_caps_t caps,
   input  wire pmq_pkg::pmq_event_t ev,
   output logic                    hit
);
   import pmq_pkg::*;

   logic core_ok;
   logic side_ok;
   logic state_ok;

   always_comb
   begin
      core_ok = 1'b1;
      if (caps.core_spec)
      begin
         case (umask[`PMQ_UM_CORE_HI:`PMQ_UM_CORE_LO])
            `PMQ_CORE_ALL:  core_ok = 1'b1;
            `PMQ_CORE_SELF: core_ok = ev.self_core;
            default:        core_ok = 1'b0;
         endcase
      end
      case (caps.side)
         PMQ_SIDE_AGENT: side_ok = umask[`PMQ_UM_AGENT] | ev.self_agent;
         PMQ_SIDE_PF:
         begin
            case (umask[`PMQ_UM_PF_HI:`PMQ_UM_PF_LO])
               `PMQ_PF_ALL:  side_ok = 1'b1;
               `PMQ_PF_ONLY: side_ok = ev.hw_pf;
               `PMQ_PF_EXCL: side_ok = ~ev.hw_pf;
               default:      side_ok = 1'b0;
            endcase
         end
         default:        side_ok = 1'b1;
      endcase
      case (caps.state)
         PMQ_ST_MESI:   state_ok = |(umask[3:0] & ev.mesi);
         PMQ_ST_SNRESP: state_ok = (umask[`PMQ_UM_HIT_MODIFIED_RESPONSE] & ev.snp_resp[2])
                                 | (umask[`PMQ_UM_HIT] & ev.snp_resp[1])
                                 | (umask[`PMQ_UM_CLEAN] & ev.snp_resp[0]);
         PMQ_ST_SNTYPE: state_ok = (umask[`PMQ_UM_SNP_INV] & ev.snp_type[1])
                                 | (umask[`PMQ_UM_SNP_SHR] & ev.snp_type[0]);
         default:       state_ok = 1'b1;
      endcase
      hit = ev.valid & core_ok & side_ok & state_ok;
   end

endmodule
`default_nettype wire

// >>> src/pmq_counter.sv
// loadable event counter with wrap flag
`timescale 1ns/1ps
`default_nettype none

module pmq_counter
#(
   parameter int W = 40
)
(
   input  wire logic         ref_clk,
   input  wire logic         clk_en,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         inc,
   output logic [W-1:0]      count,
   output logic              wrap
);

   logic [W-1:0] cnt_r;

   // contents not reset, software loads first
   // load wins over a same-cycle increment
   always_ff @(posedge ref_clk)
   begin
      if (clk_en)
      begin
         if (load)
            cnt_r <= load_val;
         else if (inc)
            cnt_r <= cnt_r + 1'b1;
      end
   end

   // wrap from all ones to zero
   assign wrap  = inc & ~load & (&cnt_r);
   assign count = cnt_r;

endmodule
`default_nettype wire

// >>> src/pmq_top.sv
// event qualification and fixed-function counters behind the msr port
`timescale 1ns/1ps
`default_nettype none
`include "pmq_params.svh"

module pmq_top
#(
   parameter int CW  = 40,
   parameter int NGP = 2,
   parameter int NFX = 3
)
(
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   input  wire logic                         clk_en,
   input  wire pmq_pkg::pmq_msr_req_t        msr_req,
   output pmq_pkg::pmq_msr_rsp_t             msr_rsp,
   input  wire logic                         ring0,
   input  wire pmq_pkg::pmq_event_t [NGP-1:0] gp_evt,
   input  wire pmq_pkg::pmq_caps_t [NGP-1:0]  gp_caps,
   output logic [NGP-1:0][7:0]               gp_evt_code,
   input  wire logic [NFX-1:0]               fix_evt,
   output logic                              pmi_req
);
   import pmq_pkg::*;

   // ************************************************
   // helpers
   // ************************************************

   // one privilege test for both counter kinds
   function automatic logic priv_ok(input logic os, input logic usr,
                                    input logic r0);
      priv_ok = (os & r0) | (usr & ~r0);
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
      is_addr = (a == b);
   endfunction

   // ************************************************
   // control registers
   // ************************************************

   logic [NGP-1:0][31:0]         sel_r;
   logic [NFX*`PMQ_FC_W-1:0]     fix_ctl_r;
   logic [NGP-1:0]               glob_gp_r;
   logic [NFX-1:0]               glob_fx_r;
   logic                         wr_ok;
   logic                         rd_ok;

   assign wr_ok = clk_en & msr_req.wr;
   assign rd_ok = clk_en & msr_req.rd;

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_r <= {NGP{`PMQ_SEL_RST}};
      end
      else if (wr_ok)
      begin
         for (int i = 0; i < NGP; i++)
         begin
            if (is_addr(msr_req.addr, 8'(`PMQ_ADDR_SEL0 + i)))
               sel_r[i] <= msr_req.wdata[31:0] & `PMQ_SEL_WMASK;
         end
      end
   end

   // bit 2 of each field dropped
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         fix_ctl_r <= `PMQ_FIXCTL_RST;
      else if (wr_ok && is_addr(msr_req.addr, `PMQ_ADDR_FIXCTL))
         fix_ctl_r <= msr_req.wdata[NFX*`PMQ_FC_W-1:0] & `PMQ_FIXCTL_WMASK;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         glob_gp_r <= NGP'(`PMQ_GLOB_RST);
         glob_fx_r <= NFX'(`PMQ_GLOB_RST);
      end
      else if (wr_ok && is_addr(msr_req.addr, `PMQ_ADDR_GLOB))
      begin
         glob_gp_r <= msr_req.wdata[`PMQ_GLOB_GP_LSB +: NGP];
         glob_fx_r <= msr_req.wdata[`PMQ_GLOB_FX_LSB +: NFX];
      end
   end

   // ************************************************
   // general-purpose counters
   // ************************************************

   logic [NGP-1:0]          gp_hit;
   logic [NGP-1:0]          gp_inc;
   logic [NGP-1:0][CW-1:0]  gp_cnt;

   for (genvar g = 0; g < NGP; g++)
   begin : g_gp
      assign gp_evt_code[g] = sel_r[g][7:0];

      pmq_umask_qual u_qual
      (
         .umask (sel_r[g][`PMQ_SEL_UM_MSB:`PMQ_SEL_UM_LSB]),
         .caps  (gp_caps[g]),
         .ev    (gp_evt[g]),
         .hit   (gp_hit[g])
      );

      assign gp_inc[g] = gp_hit[g] & sel_r[g][`PMQ_SEL_EN] & glob_gp_r[g]
                       & priv_ok(sel_r[g][`PMQ_SEL_OS], sel_r[g][`PMQ_SEL_USR], ring0);

      pmq_counter #(.W(CW)) u_cnt
      (
         .ref_clk  (ref_clk),
         .clk_en   (clk_en),
         .load     (wr_ok & is_addr(msr_req.addr, 8'(`PMQ_ADDR_GPC0 + g))),
         .load_val (msr_req.wdata[CW-1:0]),
         .inc      (gp_inc[g]),
         .count    (gp_cnt[g]),
         .wrap     ()
      );
   end

   // ************************************************
   // fixed-function counters
   // ************************************************

   logic [NFX-1:0]          fx_inc;
   logic [NFX-1:0]          fx_wrap;
   logic [NFX-1:0]          fx_pmi;
   logic [NFX-1:0][CW-1:0]  fx_cnt;

   // hardwired event, no selector or mask
   for (genvar f = 0; f < NFX; f++)
   begin : g_fx
      // bit 1 counts rings above 0
      assign fx_inc[f] = fix_evt[f] & glob_fx_r[f]
                       & priv_ok(fix_ctl_r[f*`PMQ_FC_W + `PMQ_FC_OS],
                                 fix_ctl_r[f*`PMQ_FC_W + `PMQ_FC_USR], ring0);
      assign fx_pmi[f] = fix_ctl_r[f*`PMQ_FC_W + `PMQ_FC_PMI];

      // width set by CW, 40 by default
      // bits above the width are dropped on write
      pmq_counter #(.W(CW)) u_cnt
      (
         .ref_clk  (ref_clk),
         .clk_en   (clk_en),
         .load     (wr_ok & is_addr(msr_req.addr, 8'(`PMQ_ADDR_FIX0 + f))),
         .load_val (msr_req.wdata[CW-1:0]),
         .inc      (fx_inc[f]),
         .count    (fx_cnt[f]),
         .wrap     (fx_wrap[f])
      );
   end

   // overflow request to the local interrupt controller
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pmi_req <= 1'b0;
      else if (clk_en)
         pmi_req <= |(fx_wrap & fx_pmi);
   end

   // ************************************************
   // read port
   // ************************************************

   logic [63:0] rdata_nxt;
   logic        fault_nxt;

   // unmapped reads give zero and a fault flag
   always_comb
   begin
      rdata_nxt = 64'h0;
      fault_nxt = 1'b0;
      case (msr_req.addr)
         `PMQ_ADDR_SEL0:   rdata_nxt[31:0] = sel_r[0];
         `PMQ_ADDR_SEL1:   rdata_nxt[31:0] = sel_r[1];
         `PMQ_ADDR_GPC0:   rdata_nxt[CW-1:0] = gp_cnt[0];
         `PMQ_ADDR_GPC1:   rdata_nxt[CW-1:0] = gp_cnt[1];
         `PMQ_ADDR_FIX0:   rdata_nxt[CW-1:0] = fx_cnt[0];
         `PMQ_ADDR_FIX1:   rdata_nxt[CW-1:0] = fx_cnt[1];
         `PMQ_ADDR_FIX2:   rdata_nxt[CW-1:0] = fx_cnt[2];
         `PMQ_ADDR_FIXCTL: rdata_nxt[NFX*`PMQ_FC_W-1:0] = fix_ctl_r;
         `PMQ_ADDR_GLOB:
         begin
            rdata_nxt[`PMQ_GLOB_GP_LSB +: NGP] = glob_gp_r;
            rdata_nxt[`PMQ_GLOB_FX_LSB +: NFX] = glob_fx_r;
         end
         default:          fault_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         msr_rsp <= '0;
      else if (clk_en)
      begin
         msr_rsp.valid <= msr_req.rd | msr_req.wr;
         msr_rsp.fault <= (msr_req.rd | msr_req.wr) & fault_nxt;
         msr_rsp.rdata <= msr_req.rd ? rdata_nxt : 64'h0;
      end
   end

   // ************************************************
   // assertions
   // ************************************************

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic fx0_free;
   assign fx0_free = clk_en & ~(wr_ok & is_addr(msr_req.addr, `PMQ_ADDR_FIX0));

   a_fix_ring0: assert property (
      fx0_free && fix_evt[0] && ring0 && glob_fx_r[0] && fix_ctl_r[0]
      |=> fx_cnt[0] == $past(fx_cnt[0]) + 1'b1)
      else $error("fixed counter 0 missed a ring 0 event");

   a_fix_user: assert property (
      fx0_free && fix_evt[0] && !ring0 && glob_fx_r[0] && fix_ctl_r[1]
      |=> fx_cnt[0] == $past(fx_cnt[0]) + 1'b1)
      else $error("fixed counter 0 missed a user ring event");

   a_fix_hold: assert property (
      fx0_free && fix_ctl_r[1:0] == 2'b00 |=> $stable(fx_cnt[0]))
      else $error("fixed counter 0 moved while disabled");

   a_glob_gate: assert property (
      fx0_free && !glob_fx_r[0] |=> $stable(fx_cnt[0]))
      else $error("fixed counter 0 moved without global enable");

   a_ovf_irq: assert property (
      clk_en && fx_wrap[0] && fix_ctl_r[`PMQ_FC_PMI] ##1 clk_en |-> pmi_req)
      else $error("overflow did not raise the interrupt request");

   a_no_irq: assert property (
      clk_en && !(|(fx_wrap & fx_pmi)) |=> !pmi_req)
      else $error("interrupt request without enabled overflow");

   a_ctl_rsvd: assert property (
      (fix_ctl_r & 12'h444) == 12'h000)
      else $error("reserved control bit stored");

   a_mesi_none: assert property (
      gp_caps[0].state == PMQ_ST_MESI && sel_r[0][11:8] == 4'h0 |-> !gp_hit[0])
      else $error("state qualified event counted with no state bit");

   a_core_self: assert property (
      gp_caps[0].core_spec && sel_r[0][15:14] == 2'b01 && !gp_evt[0].self_core
      |-> !gp_hit[0])
      else $error("other core counted in this-core mode");

   a_pf_excl: assert property (
      gp_caps[0].side == PMQ_SIDE_PF && sel_r[0][13:12] == 2'b00 && gp_evt[0].hw_pf
      |-> !gp_hit[0])
      else $error("prefetch counted while excluded");

   a_agent_self: assert property (
      gp_caps[0].side == PMQ_SIDE_AGENT && !sel_r[0][13] && !gp_evt[0].self_agent
      |-> !gp_hit[0])
      else $error("other agent counted in this-agent mode");

   a_fix_upper: assert property (
      rd_ok && is_addr(msr_req.addr, `PMQ_ADDR_FIX1) |=> msr_rsp.rdata[63:CW] == '0)
      else $error("fixed counter read above its width");

   c_fix_ovf: cover property (clk_en && fx_wrap[0] && fx_pmi[0] ##1 pmi_req);
   c_gp_count: cover property (clk_en && gp_inc[0] && gp_evt[0].mesi != 4'h0);
   c_read_fault: cover property (msr_rsp.valid && msr_rsp.fault);
   c_fix_all: cover property (fx_inc == 3'b111);

endmodule
`default_nettype wire

// >>> tb/pmq_top_test.sv
// self-checking bench for the event qualifier and fixed counters
`timescale 1ns/1ps
`default_nettype none
`include "pmq_params.svh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

module pmq_top_test;
   import pmq_pkg::*;

   logic             ref_clk;
   logic             sys_rst;
   logic             clk_en;
   pmq_msr_req_t     msr_req;
   pmq_msr_rsp_t     msr_rsp;
   logic             ring0;
   pmq_event_t [1:0] gp_evt;
   pmq_caps_t [1:0]  gp_caps;
   logic [1:0][7:0]  gp_evt_code;
   logic [2:0]       fix_evt;
   logic             pmi_req;
   int               num_errors = 0;
   int               samples_checked = 0;
   int               cycles = 0;
   integer           seed;
   logic [63:0]      rd;
   logic [63:0]      glob;
   logic [63:0]      ctl;
   logic [63:0]      sel [2];
   logic [63:0]      gp_m [2];
   logic [63:0]      fx_m [3];

   pmq_top #(.CW(40), .NGP(2), .NFX(3)) dut_u
   (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .clk_en      (clk_en),
      .msr_req     (msr_req),
      .msr_rsp     (msr_rsp),
      .ring0       (ring0),
      .gp_evt      (gp_evt),
      .gp_caps     (gp_caps),
      .gp_evt_code (gp_evt_code),
      .fix_evt     (fix_evt),
      .pmi_req     (pmi_req)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // ********************
   // run limit
   // ********************
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one access, then an idle cycle so the strobe is never re-driven at once
   task automatic acc(input logic w, input logic [7:0] a, input logic [63:0] d,
                      input logic flt, output logic [63:0] q);
      msr_req.wr    = w;
      msr_req.rd    = !w;
      msr_req.addr  = a;
      msr_req.wdata = d;
      @(posedge ref_clk);
      #1;
      msr_req = '0;
      `CHK("rsp_valid", 1'b1, msr_rsp.valid)
      `CHK("rsp_fault", flt, msr_rsp.fault)
      q = msr_rsp.rdata;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [63:0] d);
      logic [63:0] q;
      acc(1'b1, a, d, 1'b0, q);
   endtask

   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [63:0] ex);
      acc(1'b0, a, 64'h0, 1'b0, rd);
      `CHK(nm, ex, rd)
   endtask

   // reference qualifier worked out from the unit mask layout
   function automatic bit hit(logic [7:0] um, pmq_caps_t c, pmq_event_t e);
      bit h;
      h = e.valid;
      if (c.core_spec)
         h &= (um[7:6] == 2'b11) || (um[7:6] == 2'b01 && e.self_core);
      if (c.side == PMQ_SIDE_AGENT)
         h &= um[5] || e.self_agent;
      if (c.side == PMQ_SIDE_PF)
         h &= (um[5:4] == 2'b11) || (um[5:4] == 2'b01 && e.hw_pf) || (um[5:4] == 2'b00 && !e.hw_pf);
      if (c.state == PMQ_ST_MESI)
         h &= |(um[3:0] & e.mesi);
      if (c.state == PMQ_ST_SNRESP)
         h &= |({um[3], um[1], um[0]} & e.snp_resp);
      if (c.state == PMQ_ST_SNTYPE)
         h &= |(um[1:0] & e.snp_type);
      return h;
   endfunction

   initial
   begin
      seed    = 32'h1b3901e3;
      sys_rst = 1'b1;
      clk_en  = 1'b1;
      msr_req = '0;
      ring0   = 1'b0;
      gp_evt  = '0;
      gp_caps = {2{1'b0, PMQ_SIDE_NONE, PMQ_ST_NONE}};
      fix_evt = 3'h0;
      repeat (5) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      // counters come up undefined, so give all five a known value first
      for (int i = 0; i < 5; i++)
         wr(`PMQ_ADDR_GPC0 + 8'(i), 64'h0);

      // ********************
      // registers
      // ********************
      chk_rd("fixctl_rst", `PMQ_ADDR_FIXCTL, 64'h0);
      chk_rd("glob_rst", `PMQ_ADDR_GLOB, 64'h0);
      wr(`PMQ_ADDR_FIXCTL, 64'hfff);
      chk_rd("fixctl_mask", `PMQ_ADDR_FIXCTL, 64'hbbb);
      wr(`PMQ_ADDR_SEL1, 64'h3ffff);
      chk_rd("sel_mask", `PMQ_ADDR_SEL1, 64'h3ffff);
      acc(1'b0, 8'h09, 64'h0, 1'b1, rd);
      `CHK("unmapped_rdata", 64'h0, rd)
      $display("register test done");

      // ********************
      // random qualification and privilege counting
      // ********************
      for (int p = 0; p < 16; p++)
      begin
         for (int g = 0; g < 2; g++)
         begin
            sel[g] = 64'h400000 | (64'($random(seed)) & 64'h3ffff);
            wr(`PMQ_ADDR_SEL0 + 8'(g), sel[g]);
            `CHK("evt_code", sel[g][7:0], gp_evt_code[g])
            gp_caps[g].core_spec = 1'($random(seed));
            gp_caps[g].side  = pmq_side_t'(3'b001 << ($unsigned($random(seed)) % 3));
            gp_caps[g].state = pmq_state_t'(4'b0001 << ($unsigned($random(seed)) % 4));
            gp_m[g] = 64'($unsigned($random(seed)));
            wr(`PMQ_ADDR_GPC0 + 8'(g), gp_m[g]);
         end
         for (int i = 0; i < 3; i++)
         begin
            fx_m[i] = 64'($unsigned($random(seed)));
            wr(`PMQ_ADDR_FIX0 + 8'(i), fx_m[i]);
         end
         ctl  = 64'($random(seed)) & 64'h333;
         glob = p[0] ? (64'($random(seed)) & 64'h7_0000_0003) : 64'h7_0000_0003;
         wr(`PMQ_ADDR_FIXCTL, ctl);
         wr(`PMQ_ADDR_GLOB, glob);
         repeat (40)
         begin
            clk_en  = ($random(seed) & 7) != 0;
            ring0   = 1'($random(seed));
            fix_evt = 3'($random(seed));
            gp_evt  = 26'($random(seed));
            for (int g = 0; g < 2; g++)
               if (clk_en && hit(sel[g][15:8], gp_caps[g], gp_evt[g]) && sel[g][22] && glob[g]
                   && ((sel[g][17] && ring0) || (sel[g][16] && !ring0)))
                  gp_m[g]++;
            for (int i = 0; i < 3; i++)
               if (clk_en && fix_evt[i] && glob[32+i]
                   && ((ctl[4*i] && ring0) || (ctl[4*i+1] && !ring0)))
                  fx_m[i]++;
            @(posedge ref_clk);
            #1;
         end
         clk_en  = 1'b1;
         fix_evt = 3'h0;
         gp_evt  = '0;
         for (int g = 0; g < 2; g++)
            chk_rd("gp_count", `PMQ_ADDR_GPC0 + 8'(g), gp_m[g]);
         for (int i = 0; i < 3; i++)
            chk_rd("fix_count", `PMQ_ADDR_FIX0 + 8'(i), fx_m[i]);
      end
      $display("counting test done");

      // ********************
      // wrap and overflow request, with and without its enable
      // ********************
      // counters 0 and 1, each with the interrupt enable off and then on
      for (int k = 0; k < 4; k++)
      begin
         wr(`PMQ_ADDR_FIX0 + 8'(k / 2), 64'hff_ffff_ffff);
         wr(`PMQ_ADDR_FIXCTL, (k[0] ? 64'hb : 64'h3) << (4 * (k / 2)));
         wr(`PMQ_ADDR_GLOB, 64'h1_0000_0000 << (k / 2));
         ring0   = 1'b1;
         fix_evt = 3'(3'b001 << (k / 2));
         @(posedge ref_clk);
         #1;
         fix_evt = 3'h0;
         `CHK("pmi_req", k[0], pmi_req)
         @(posedge ref_clk);
         #1;
         `CHK("pmi_pulse", 1'b0, pmi_req)
         chk_rd("wrap", `PMQ_ADDR_FIX0 + 8'(k / 2), 64'h0);
      end
      $display("overflow test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
